// ==== common/epc_pkg.sv ====
// shared constants and types for the encoder position counter
package epc_pkg;
    // sizes
    localparam int NUM_CH = 3;
    localparam int CNT_W = 32;
    localparam int EXPO_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // per-channel register window and shared registers, byte addresses
    localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h10;
    localparam logic [ADDR_W-1:0] CH_CFG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CH_MAX_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CH_PRESET_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] CH_CMD_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] LIVE_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] LATCH_BASE = 8'h50;
    localparam logic [ADDR_W-1:0] EXPO_STAT_OFS = 8'h60;
    localparam logic [ADDR_W-1:0] MEAS_SEQ_OFS = 8'h64;
    // field positions
    localparam int CFG_INTERP_LSB = 0;
    localparam int CFG_REF_LSB = 2;
    localparam int CMD_SET_BIT = 0;
    localparam int CMD_NEXT_BIT = 1;
    localparam int CMD_RSTREF_BIT = 2;
    localparam int STAT_SEEN_BIT = 0;
    localparam int EXPO_BUSY_BIT = 0;
    localparam int EXPO_OVR_BIT = 1;
    // reset values
    localparam logic [CNT_W-1:0] MAX_RST = 32'hFFFF_FFFF;
    localparam logic [CNT_W-1:0] PRESET_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = PRESET_RST;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
    localparam logic [EXPO_W-1:0] TIMER_RST = 16'h0000;

    typedef enum logic [1:0] {
        EPC_INTERP_X1 = 2'h0,
        EPC_INTERP_X2 = 2'h1,
        EPC_INTERP_X4 = 2'h2
    } epc_interp_t;

    typedef enum logic [1:0] {
        EPC_REF_NONE = 2'h0,
        EPC_REF_FIRST = 2'h1,
        EPC_REF_EVERY = 2'h2
    } epc_refmode_t;

    typedef struct packed {
        logic [1:0] interp;
        logic [1:0] refmode;
        logic [CNT_W-1:0] max_val;
        logic [CNT_W-1:0] preset;
    } epc_cfg_t;

    typedef struct packed {
        logic set_value;
        logic next_mark;
        logic reset_ref;
    } epc_cmd_t;

    typedef struct packed {
        logic valid;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    } epc_meas_t;
endpackage : epc_pkg

// ==== hw/epc_quad_decoder.sv ====
// two-track quadrature decoder with selectable interpolation
`timescale 1ns/1ps
`default_nettype none
module epc_quad_decoder
    import epc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic trk_a, // encoder track a
    input wire logic trk_b, // encoder track b
    input wire logic [1:0] interp, // interpolation select
    output logic step, // one counted edge
    output logic step_up // direction of that edge
);
    logic a_reg, a_next, b_reg, b_next, primed_reg, primed_next;
    logic a_rise, a_fall, b_rise, b_fall, up_a, up_b;

    // edge detection and direction
    always_comb
    begin
        a_next = trk_a;
        b_next = trk_b;
        primed_next = 1'b1;
        a_rise = primed_reg & trk_a & ~a_reg;
        a_fall = primed_reg & ~trk_a & a_reg;
        b_rise = primed_reg & trk_b & ~b_reg;
        b_fall = primed_reg & ~trk_b & b_reg;
        up_a = a_rise ? ~trk_b : trk_b; // a leads b: up
        up_b = b_rise ? trk_a : ~trk_a;
        step = 1'b0;
        step_up = up_a;
        case (interp)
            EPC_INTERP_X1: step = a_rise;
            EPC_INTERP_X2: step = a_rise | a_fall;
            EPC_INTERP_X4:
            begin
                step = a_rise | a_fall | b_rise | b_fall;
                step_up = (a_rise | a_fall) ? up_a : up_b;
            end
            default: step = 1'b0;
        endcase
    end

    // previous track levels
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_reg <= 1'b0;
            b_reg <= 1'b0;
            primed_reg <= 1'b0;
        end
        else
        begin
            a_reg <= a_next;
            b_reg <= b_next;
            primed_reg <= primed_next;
        end
    end
endmodule : epc_quad_decoder
`default_nettype wire

// ==== hw/epc_chan_counter.sv ====
// one channel counter: wrap at maximum, preset, reference mark
`timescale 1ns/1ps
`default_nettype none
module epc_chan_counter
    import epc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic step, // counted edge
    input wire logic step_up, // count direction
    input wire logic ref_mark, // reference track level
    input wire epc_cfg_t cfg, // channel settings
    input wire epc_cmd_t cmd, // one-cycle commands
    output logic [CNT_W-1:0] count, // current count
    output logic ref_seen // a mark has loaded the count
);
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic seen_reg, seen_next, z_reg, z_next, z_rise, load_ref;

    // count, reload and mark bookkeeping
    always_comb
    begin
        z_next = ref_mark;
        z_rise = ref_mark & ~z_reg;
        load_ref = 1'b0;
        if (z_rise && cfg.refmode == EPC_REF_FIRST && !seen_reg)
            load_ref = 1'b1;
        if (z_rise && cfg.refmode == EPC_REF_EVERY)
            load_ref = 1'b1;
        // none mode never loads on a mark
        seen_next = seen_reg;
        if (cmd.next_mark || cmd.reset_ref)
            seen_next = 1'b0;
        if (load_ref)
            seen_next = 1'b1; // set wins over clear
        cnt_next = cnt_reg;
        if (cmd.set_value)
            cnt_next = cfg.preset;
        else if (load_ref)
            cnt_next = cfg.preset;
        else if (step && step_up)
            cnt_next = (cnt_reg >= cfg.max_val) ? CNT_RST
                : cnt_reg + 32'h0000_0001;
        else if (step)
            cnt_next = (cnt_reg == CNT_RST) ? cfg.max_val
                : cnt_reg - 32'h0000_0001;
    end

    // state registers; reset loads the reset preset
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg <= CNT_RST;
            seen_reg <= 1'b0;
            z_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            seen_reg <= seen_next;
            z_reg <= z_next;
        end
    end

    assign count = cnt_reg;
    assign ref_seen = seen_reg;
endmodule : epc_chan_counter
`default_nettype wire

// ==== hw/epc_top.sv ====
// encoder position counter: three channels, registers, mid-exposure latch
//
// Contract
// - each channel counts single, double or quadruple edges per period.
// - the counter steps by one on each counted edge, following direction.
// - direction comes from the phase of track a against track b.
// - passing the configured maximum returns the count to zero.
// - the counter is 32 bits wide, reaching all ones at most.
// - in no-effect mode marks are ignored; preset only at reset or command.
// - first-mark mode loads the preset on the first mark after power-up.
// - first-mark mode re-arms after the next-mark or reset-reference command.
// - every-mark mode reloads the preset on every mark crossed.
// - the reset-reference command clears the mark-seen state.
// - the preset loads at every power-up and on the set-value command.
// - all counts are latched at mid-exposure and output with the value.
// - up to three channels, each with own settings, usable for triggers.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module epc_top
    import epc_pkg::*;
(
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rst_b, // async reset, active low
    input wire logic [NUM_CH-1:0] enc_a, // track a per channel
    input wire logic [NUM_CH-1:0] enc_b, // track b per channel
    input wire logic [NUM_CH-1:0] enc_ref, // reference track
    input wire logic expo_start, // exposure begins, pulse
    input wire logic [EXPO_W-1:0] expo_cycles, // exposure length
    input wire logic [ADDR_W-1:0] reg_addr, // register byte address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, next cycle
    output logic [NUM_CH-1:0][CNT_W-1:0] cnt_live, // counts for triggers
    output epc_meas_t meas // latched counts per value
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HALF = 2'b01
    } epc_state_t;

    epc_cfg_t [NUM_CH-1:0] cfg_reg, cfg_next;
    epc_cmd_t [NUM_CH-1:0] cmd;
    logic [NUM_CH-1:0][CNT_W-1:0] count;
    logic [NUM_CH-1:0] seen;
    logic [NUM_CH-1:0] step, step_up;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    epc_state_t state_reg, state_next;
    logic [EXPO_W-1:0] timer_reg, timer_next;
    logic [EXPO_W-1:0] half_len;
    epc_meas_t meas_reg, meas_next;
    logic ovr_reg, ovr_next;
    logic [DATA_W-1:0] seq_reg, seq_next;
    logic do_latch;

    // per-channel decoder and counter
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            epc_quad_decoder u_dec (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .trk_a(enc_a[g]),
                .trk_b(enc_b[g]),
                .interp(cfg_reg[g].interp),
                .step(step[g]),
                .step_up(step_up[g])
            );
            epc_chan_counter u_cnt (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .step(step[g]),
                .step_up(step_up[g]),
                .ref_mark(enc_ref[g]),
                .cfg(cfg_reg[g]),
                .cmd(cmd[g]),
                .count(count[g]),
                .ref_seen(seen[g])
            );
        end
    endgenerate

    // configuration writes and command pulses
    always_comb
    begin
        cfg_next = cfg_reg;
        cmd = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (reg_wr && reg_addr == (ADDR_W'(c) * CH_STRIDE
                + CH_CFG_OFS))
            begin
                cfg_next[c].interp =
                    reg_wdata[CFG_INTERP_LSB +: 2];
                cfg_next[c].refmode = reg_wdata[CFG_REF_LSB +: 2];
            end
            else if (reg_wr && reg_addr == (ADDR_W'(c) * CH_STRIDE
                + CH_MAX_OFS))
            begin
                cfg_next[c].max_val = reg_wdata;
            end
            else if (reg_wr && reg_addr == (ADDR_W'(c) * CH_STRIDE
                + CH_PRESET_OFS))
            begin
                // value range left to software
                cfg_next[c].preset = reg_wdata;
            end
            else if (reg_wr && reg_addr == (ADDR_W'(c) * CH_STRIDE
                + CH_CMD_OFS))
            begin
                cmd[c].set_value = reg_wdata[CMD_SET_BIT];
                cmd[c].next_mark = reg_wdata[CMD_NEXT_BIT];
                cmd[c].reset_ref = reg_wdata[CMD_RSTREF_BIT];
            end
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                cfg_reg[c].interp <= EPC_INTERP_X1;
                cfg_reg[c].refmode <= EPC_REF_NONE;
                cfg_reg[c].max_val <= MAX_RST;
                cfg_reg[c].preset <= PRESET_RST;
            end
        end
        else
        begin
            cfg_reg <= cfg_next;
        end
    end

    // read mux, data stands only in the cycle after the strobe
    always_comb
    begin
        rdata_next = RDATA_RST;
        if (reg_rd)
        begin
            if (reg_addr == EXPO_STAT_OFS)
            begin
                rdata_next[EXPO_BUSY_BIT] = (state_reg == ST_HALF);
                rdata_next[EXPO_OVR_BIT] = ovr_reg;
            end
            else if (reg_addr == MEAS_SEQ_OFS)
            begin
                rdata_next = seq_reg;
            end
            else
            begin
                for (int c = 0; c < NUM_CH; c++)
                begin
                    if (reg_addr == (ADDR_W'(c) * CH_STRIDE
                        + CH_CFG_OFS))
                    begin
                        rdata_next[CFG_INTERP_LSB +: 2] =
                            cfg_reg[c].interp;
                        rdata_next[CFG_REF_LSB +: 2] =
                            cfg_reg[c].refmode;
                    end
                    else if (reg_addr == (ADDR_W'(c) * CH_STRIDE
                        + CH_MAX_OFS))
                    begin
                        rdata_next = cfg_reg[c].max_val;
                    end
                    else if (reg_addr == (ADDR_W'(c) * CH_STRIDE
                        + CH_PRESET_OFS))
                    begin
                        rdata_next = cfg_reg[c].preset;
                    end
                    else if (reg_addr == (ADDR_W'(c) * CH_STRIDE
                        + CH_CMD_OFS))
                    begin
                        rdata_next[STAT_SEEN_BIT] = seen[c];
                    end
                    else if (reg_addr == (LIVE_BASE
                        + ADDR_W'(4 * c)))
                    begin
                        rdata_next = count[c];
                    end
                    else if (reg_addr == (LATCH_BASE
                        + ADDR_W'(4 * c)))
                    begin
                        rdata_next = meas_reg.cnt[c];
                    end
                end
            end
        end
    end

    // read data register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_reg <= RDATA_RST;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // mid-exposure timer: wait half the exposure, then latch
    always_comb
    begin
        half_len = expo_cycles >> 1;
        state_next = state_reg;
        timer_next = timer_reg;
        do_latch = 1'b0;
        ovr_next = ovr_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (expo_start && half_len == TIMER_RST)
                    do_latch = 1'b1;
                else if (expo_start)
                begin
                    timer_next = half_len - 16'h0001;
                    state_next = ST_HALF;
                end
            end
            ST_HALF:
            begin
                if (timer_reg == TIMER_RST)
                begin
                    do_latch = 1'b1;
                    state_next = ST_IDLE;
                end
                else
                begin
                    timer_next = timer_reg - 16'h0001;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        // overrun: start refused while waiting; write one clears
        if (reg_wr && reg_addr == EXPO_STAT_OFS
            && reg_wdata[EXPO_OVR_BIT])
            ovr_next = 1'b0;
        if (expo_start && state_reg == ST_HALF)
            ovr_next = 1'b1;
    end

    // latched counts and measurement sequence
    always_comb
    begin
        meas_next = meas_reg;
        meas_next.valid = do_latch;
        seq_next = seq_reg;
        if (do_latch)
        begin
            meas_next.cnt = count; // all channels at once
            seq_next = seq_reg + 32'h0000_0001;
        end
    end

    // timer and latch registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            timer_reg <= TIMER_RST;
            ovr_reg <= 1'b0;
            meas_reg <= '0;
            seq_reg <= RDATA_RST;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            ovr_reg <= ovr_next;
            meas_reg <= meas_next;
            seq_reg <= seq_next;
        end
    end

    // outputs
    assign reg_rdata = rdata_reg;
    assign cnt_live = count; // from counter flops
    assign meas = meas_reg;
endmodule : epc_top
`default_nettype wire

// ==== tb/epc_top_sva.sv ====
// assertion checker for the encoder position counter top
`timescale 1ns/1ps
`default_nettype none
module epc_top_chk
    import epc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [NUM_CH-1:0] enc_a, // track a
    input wire logic [NUM_CH-1:0] enc_b, // track b
    input wire logic [NUM_CH-1:0] enc_ref, // reference track
    input wire logic expo_start, // exposure begins
    input wire logic [EXPO_W-1:0] expo_cycles, // exposure length
    input wire logic [ADDR_W-1:0] reg_addr, // register address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire logic [NUM_CH-1:0][CNT_W-1:0] cnt_live, // live counts
    input wire epc_meas_t meas // latched counts
);
    logic [CNT_W-1:0] pre_reg; // channel 0 preset as written
    logic [1:0] mode_reg; // channel 0 reference mode as written
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // shadow of channel 0 settings, needed to judge loads
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
            {mode_reg, pre_reg} <= {2'h0, PRESET_RST};
        else if (reg_wr && reg_addr == CH_CFG_OFS)
            mode_reg <= reg_wdata[CFG_REF_LSB +: 2];
        else if (reg_wr && reg_addr == CH_PRESET_OFS)
            pre_reg <= reg_wdata;
    // exposure of eight: four quiet cycles, then the latch
    sequence s_wait;
        (!meas.valid) [*4] ##1 meas.valid;
    endsequence
    property p_hold;
        (!reg_wr && $stable(enc_a[0]) && $stable(enc_b[0])
            && $stable(enc_ref[0])) [*4] |=> $stable(cnt_live[0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved without cause");
    property p_ignore;
        (!reg_wr && mode_reg == EPC_REF_NONE && $stable(enc_a[0])
            && $stable(enc_b[0])) [*4] |=> $stable(cnt_live[0]);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("mark moved count in no-effect mode");
    property p_set;
        reg_wr && reg_addr == CH_CMD_OFS && reg_wdata[CMD_SET_BIT]
            |=> cnt_live[0] == pre_reg;
    endproperty
    a_set: assert property (p_set)
        else $error("set-value did not load preset");
    property p_every;
        $rose(enc_ref[0]) && mode_reg == EPC_REF_EVERY
            |-> ##[1:4] cnt_live[0] == pre_reg;
    endproperty
    a_every: assert property (p_every)
        else $error("mark did not reload preset");
    property p_latch;
        meas.valid |-> meas.cnt == $past(cnt_live);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latched counts differ from live counts");
    property p_keep;
        !meas.valid |-> $stable(meas.cnt);
    endproperty
    a_keep: assert property (p_keep)
        else $error("latched counts changed between latches");
    property p_mid;
        expo_start && expo_cycles == 16'h0008 |=> s_wait;
    endproperty
    a_mid: assert property (p_mid)
        else $error("latch not at mid-exposure");
    property p_rd;
        !$past(reg_rd) |-> reg_rdata == RDATA_RST;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data outside its cycle");
endmodule : epc_top_chk
`default_nettype wire

// ==== tb/epc_enc_model.sv ====
// encoder model: two-phase tracks and reference mark per channel
`timescale 1ns/1ps
`default_nettype none
module epc_enc_model
    import epc_pkg::*;
(
    input wire logic ref_clk, // system clock
    output logic [NUM_CH-1:0] trk_a, // track a
    output logic [NUM_CH-1:0] trk_b, // track b
    output logic [NUM_CH-1:0] mark // reference track
);
    int ph [NUM_CH] = '{default: 0}; // quadrature phase 0 to 3
    // tracks and marks rest low
    initial
    begin
        trk_a = '0;
        trk_b = '0;
        mark = '0;
    end
    // whole periods, four edges each; moving up a leads b
    task automatic move(input int ch, input bit up, input int n);
        repeat (4 * n)
        begin
            ph[ch] = up ? (ph[ch] + 1) % 4 : (ph[ch] + 3) % 4;
            @(posedge ref_clk);
            trk_a[ch] <= ph[ch] == 1 || ph[ch] == 2;
            trk_b[ch] <= ph[ch] >= 2;
            repeat (3) @(posedge ref_clk);
        end
    endtask : move
    // one reference mark, tracks held still
    task automatic pulse_mark(input int ch);
        @(posedge ref_clk);
        mark[ch] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        mark[ch] <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse_mark
endmodule : epc_enc_model
`default_nettype wire

// ==== tb/test_epc_top.sv ====
// self-checking bench for the encoder position counter
`timescale 1ns/1ps
`default_nettype none
module test_epc_top;
    import epc_pkg::*;
    typedef struct {int ch; logic [1:0] ip; bit up; int n; int d;} epc_row_t;
    logic ref_clk, rst_b;
    logic [NUM_CH-1:0] enc_a, enc_b, enc_ref;
    logic expo_start = 1'b0;
    logic [EXPO_W-1:0] expo_cycles = '0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_live;
    epc_meas_t meas;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [EXPO_W-1:0] lens [3] = '{16'h0008, 16'h0003, 16'h0001};
    epc_row_t rows [6] = '{'{0, EPC_INTERP_X1, 1'b1, 2, 2},
        '{1, EPC_INTERP_X2, 1'b1, 2, 4}, '{2, EPC_INTERP_X4, 1'b1, 2, 8},
        '{0, EPC_INTERP_X4, 1'b0, 1, -4}, '{1, EPC_INTERP_X2, 1'b0, 1, -2},
        '{2, EPC_INTERP_X1, 1'b0, 3, -3}};

    epc_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .enc_a(enc_a),
        .enc_b(enc_b), .enc_ref(enc_ref), .expo_start(expo_start),
        .expo_cycles(expo_cycles), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cnt_live(cnt_live), .meas(meas));
    epc_enc_model i_enc (.ref_clk(ref_clk), .trk_a(enc_a), .trk_b(enc_b),
        .mark(enc_ref));

    // 200 MHz clock and a cycle count for latency checks
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic close_out();
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [ADDR_W-1:0] ch_addr(input int ch,
        input logic [ADDR_W-1:0] ofs);
        return ADDR_W'(ch) * CH_STRIDE + ofs;
    endfunction : ch_addr
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rdchk
    task automatic setup(input int ch, logic [1:0] ip, md,
        logic [CNT_W-1:0] mx, pre);
        wr(ch_addr(ch, CH_CFG_OFS), DATA_W'({md, ip}));
        wr(ch_addr(ch, CH_MAX_OFS), mx);
        wr(ch_addr(ch, CH_PRESET_OFS), pre);
        wr(ch_addr(ch, CH_CMD_OFS), 32'h1 << CMD_SET_BIT);
    endtask : setup
    task automatic cnt_is(input int ch, logic [CNT_W-1:0] e);
        repeat (6) @(posedge ref_clk);
        #1;
        chk(cnt_live[ch], e);
        rdchk(LIVE_BASE + ADDR_W'(4 * ch), e);
    endtask : cnt_is
    // start an exposure, optionally move channel 0, time the latch
    task automatic expose(input logic [EXPO_W-1:0] len, input int mv);
        int c0;
        @(posedge ref_clk);
        expo_start <= 1'b1;
        expo_cycles <= len;
        @(posedge ref_clk);
        expo_start <= 1'b0;
        #1;
        c0 = cyc;
        if (mv > 0)
            i_enc.move(0, 1'b1, mv);
        #1;
        for (int k = 0; k < 400 && meas.valid !== 1'b1; k++)
            @(posedge ref_clk) #1;
        if (meas.valid !== 1'b1)
        begin
            errors++;
            close_out();
        end
        chk(DATA_W'(cyc - c0), DATA_W'(len >> 1));
    endtask : expose

    // main sequence
    initial
    begin
        rst_b = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdchk(ch_addr(0, CH_MAX_OFS), MAX_RST);
        rdchk(ch_addr(0, CH_PRESET_OFS), PRESET_RST);
        cnt_is(0, CNT_RST);
        wr(8'h30, 32'hFFFF_FFFF);
        rdchk(8'h30, 32'h0000_0000);
        foreach (rows[i])
        begin
            setup(rows[i].ch, rows[i].ip, EPC_REF_NONE, MAX_RST, 32'h100);
            i_enc.move(rows[i].ch, rows[i].up, rows[i].n);
            cnt_is(rows[i].ch, 32'h100 + rows[i].d);
        end
        setup(0, EPC_INTERP_X4, EPC_REF_NONE, 32'h105, 32'h100);
        i_enc.move(0, 1'b1, 2);
        cnt_is(0, 32'h0000_0002);
        setup(1, EPC_INTERP_X1, EPC_REF_NONE, MAX_RST, 32'hFFFF_FFFE);
        i_enc.move(1, 1'b1, 1);
        cnt_is(1, 32'hFFFF_FFFF);
        i_enc.move(1, 1'b1, 1);
        cnt_is(1, 32'h0000_0000);
        setup(0, EPC_INTERP_X4, EPC_REF_NONE, MAX_RST, 32'h50);
        i_enc.move(0, 1'b1, 1);
        i_enc.pulse_mark(0);
        cnt_is(0, 32'h0000_0054);
        // second reset in mid-run, then the first-mark mode
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        cnt_is(0, CNT_RST);
        setup(0, EPC_INTERP_X4, EPC_REF_FIRST, MAX_RST, 32'h20);
        for (int k = 0; k < 4; k++)
        begin
            i_enc.move(0, 1'b1, 1);
            if (k == 2)
                wr(CH_CMD_OFS, 32'h1 << CMD_NEXT_BIT);
            if (k == 3)
                wr(CH_CMD_OFS, 32'h1 << CMD_RSTREF_BIT);
            if (k == 3)
                rdchk(CH_CMD_OFS, 32'h0000_0000);
            i_enc.pulse_mark(0);
            cnt_is(0, k == 1 ? 32'h24 : 32'h20);
        end
        rdchk(CH_CMD_OFS, 32'h1 << STAT_SEEN_BIT);
        setup(0, EPC_INTERP_X2, EPC_REF_EVERY, MAX_RST, 32'h30);
        for (int k = 0; k < 2; k++)
        begin
            i_enc.move(0, k == 0, 1);
            i_enc.pulse_mark(0);
            cnt_is(0, 32'h0000_0030);
        end
        setup(0, EPC_INTERP_X4, EPC_REF_NONE, MAX_RST, 32'h10);
        foreach (lens[i])
        begin
            expose(lens[i], 0);
            chk(meas.cnt[0], 32'h0000_0010);
            chk(meas.cnt[2], CNT_RST);
        end
        expose(16'h00C8, 1);
        chk(meas.cnt[0], 32'h0000_0014);
        i_enc.move(0, 1'b1, 1);
        cnt_is(0, 32'h0000_0018);
        chk(meas.cnt[0], 32'h0000_0014);
        // a start while waiting is dropped and flags overrun
        @(posedge ref_clk);
        expo_start <= 1'b1;
        expo_cycles <= 16'h000A;
        @(posedge ref_clk);
        @(posedge ref_clk);
        expo_start <= 1'b0;
        rdchk(EXPO_STAT_OFS, 32'h0000_0003);
        wr(EXPO_STAT_OFS, 32'h1 << EXPO_OVR_BIT);
        rdchk(EXPO_STAT_OFS, 32'h0000_0000);
        rdchk(MEAS_SEQ_OFS, 32'h0000_0005);
        close_out();
    end
endmodule : test_epc_top
bind epc_top epc_top_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .enc_a(enc_a), .enc_b(enc_b), .enc_ref(enc_ref),
    .expo_start(expo_start), .expo_cycles(expo_cycles),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_live(cnt_live),
    .meas(meas));
`default_nettype wire
